// file: design/ucb_pkg.sv
/*
 * Package for the descriptor-table base and configuration slice of the
 * full-speed USB controller: register offsets, field positions, reset
 * values, bus widths and the eye-pattern timing.
 * Assumes a single 40 MHz system clock and a plain register port.
 */
package ucb_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte addresses on the plain port
    localparam logic [7:0] OFS_BASE_LOW  = 8'h00;
    localparam logic [7:0] OFS_BASE_MID  = 8'h04;
    localparam logic [7:0] OFS_BASE_HIGH = 8'h08;
    localparam logic [7:0] OFS_CONFIG    = 8'h0C;

    // Field positions inside the low byte
    localparam int LOW_FIELD_LSB = 1;
    localparam int LOW_FIELD_MSB = 7;
    localparam int CFG_EYE_BIT   = 7;
    localparam int CFG_OEMON_BIT = 6;
    localparam int CFG_HALT_BIT  = 4;
    localparam int CFG_ASUSP_BIT = 0;
    localparam int BYTE_MSB      = 7;

    // Descriptor table alignment: 512 bytes
    localparam int ALIGN_BITS = 9;

    // Reset values
    localparam logic [6:0]  RST_BASE_LOW  = 7'h00;
    localparam logic [7:0]  RST_BASE_BYTE = 8'h00;
    localparam logic [31:0] ZERO_WORD     = 32'h00000000;
    localparam logic [23:0] ZERO_UPPER    = 24'h000000;
    localparam logic [8:0]  ZERO_ALIGN    = 9'h000;

    // Eye-pattern bit time: one full-speed bit, longest time rounds down
    localparam int EYE_BIT_PS   = 83333;
    localparam int CLK_PERIOD_PS = 25000;
    localparam int EYE_BIT_CYC_I = (EYE_BIT_PS / CLK_PERIOD_PS) < 1 ? 1 : (EYE_BIT_PS / CLK_PERIOD_PS);
    localparam logic [3:0] EYE_BIT_CYC = 4'(EYE_BIT_CYC_I);
    localparam logic [3:0] EYE_CNT_ONE = 4'h1;
    localparam logic [3:0] EYE_CNT_ZERO = 4'h0;

    // Stored configuration controls
    typedef struct packed {
        logic eye_pattern_test_enable;
        logic drive_enable_monitor;
        logic halt_in_idle;
        logic auto_suspend_on_sleep;
    } ucb_cfg_type;

    localparam ucb_cfg_type RST_CFG = '{1'b0, 1'b0, 1'b0, 1'b0};

    // Line state driven during the eye-pattern test
    typedef struct packed {
        logic dp;
        logic dm;
    } ucb_line_type;

endpackage

// file: design/ucb_eye_gen.sv
/*
 * Eye-pattern generator: toggles a differential J/K pattern once per
 * full-speed bit time while enabled, idles at J otherwise.
 * Assumes the 40 MHz system clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module ucb_eye_gen (
    input  wire logic                  clk,      // System clock
    input  wire logic                  rst,      // Synchronous reset
    input  wire logic                  enable,   // Pattern running
    output var  ucb_pkg::ucb_line_type line      // Pattern on D+/D-
);

    logic [3:0] bit_cnt;
    logic       bit_tick;

    // Bit-rate enable pulse from the divider
    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            bit_cnt <= ucb_pkg::EYE_CNT_ZERO;
        end else if (bit_tick) begin
            bit_cnt <= ucb_pkg::EYE_CNT_ZERO;
        end else begin
            bit_cnt <= bit_cnt + ucb_pkg::EYE_CNT_ONE;
        end
    end

    assign bit_tick = (bit_cnt == (ucb_pkg::EYE_BIT_CYC - ucb_pkg::EYE_CNT_ONE));

    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            line <= '{1'b1, 1'b0};
        end else if (bit_tick) begin
            line <= '{~line.dp, ~line.dm};
        end
    end

endmodule

`default_nettype wire

// file: design/ucb_config.sv
/*
 * Descriptor-table base address registers and configuration register
 * of the full-speed USB controller, with their effect on eye-pattern
 * test, drive-enable monitor, halt in idle and suspend on sleep.
 * Assumes a plain register port synchronous to the 40 MHz clock, and
 * power-state and line-drive inputs synchronous to the same clock.
 */
// Contract
// - Low page register bits 7:1 hold writable table base bits 15:9.
// - Mid page register bits 7:0 hold writable table base bits 23:16.
// - High page register bits 7:0 hold writable table base bits 31:24.
// - Table base is 512-byte aligned; its low nine bits are zero.
// - Bit 0 of the low page register is absent and reads zero.
// - Bits 31:8 of all four registers read zero and ignore writes.
// - Eye control at config bit 7 drives the eye-pattern test when set.
// - Monitor control at bit 6 shows when the D+/D- lines are driven.
// - Halt control at bit 4 stops the module during system idle.
// - Auto-suspend at bit 0 suspends the module on sleep entry.
// - Without auto-suspend, only the manual suspend control suspends and stops 48 MHz.
// - All implemented bits reset to zero.
`timescale 1ns/1ps
`default_nettype none

module ucb_config (
    input  wire logic        CLK,             // 40 MHz system clock
    input  wire logic        SYS_RST,         // Synchronous reset, high
    input  wire logic [7:0]  ADDR,            // Register byte address
    input  wire logic [31:0] WDATA,           // Write data
    input  wire logic        WR,              // Write strobe
    input  wire logic        RD,              // Read strobe
    output logic      [31:0] RDATA,           // Read data, cycle after RD
    input  wire logic        SYSTEM_IDLE,     // System in idle mode
    input  wire logic        SYSTEM_SLEEP,    // System in sleep mode
    input  wire logic        MANUAL_SUSPEND,  // Suspend control from power register
    input  wire logic        LINE_DRIVE,      // Transceiver drives D+/D-
    output logic      [31:0] TABLE_BASE,      // Descriptor table base address
    output logic             EYE_OE,          // Eye pattern drives the lines
    output logic             EYE_DP,          // Eye pattern D+
    output logic             EYE_DM,          // Eye pattern D-
    output logic             OE_MONITOR,      // Drive-enable indication
    output logic             MODULE_HALTED,   // Module operation halted
    output logic             MODULE_SUSPEND,  // Module suspended
    output logic             CLK48_STOP       // Request to stop 48 MHz clock
);

    logic [6:0]           table_base_bits_15_9;
    logic [7:0]           table_base_bits_23_16;
    logic [7:0]           table_base_bits_31_24;
    ucb_pkg::ucb_cfg_type cfg;
    logic [31:0]          next_rdata;
    logic                 next_halt;
    logic                 next_suspend;
    logic                 eye_run;
    ucb_pkg::ucb_line_type eye_line;

    logic hit_low;
    logic hit_mid;
    logic hit_high;
    logic hit_cfg;

    assign hit_low  = (ADDR == ucb_pkg::OFS_BASE_LOW);
    assign hit_mid  = (ADDR == ucb_pkg::OFS_BASE_MID);
    assign hit_high = (ADDR == ucb_pkg::OFS_BASE_HIGH);
    assign hit_cfg  = (ADDR == ucb_pkg::OFS_CONFIG);

    // Base address bits 15:9
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            table_base_bits_15_9 <= ucb_pkg::RST_BASE_LOW;
        end else if (WR && hit_low) begin
            table_base_bits_15_9 <= WDATA[ucb_pkg::LOW_FIELD_MSB:ucb_pkg::LOW_FIELD_LSB];
        end
    end

    // Base address bits 23:16
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            table_base_bits_23_16 <= ucb_pkg::RST_BASE_BYTE;
        end else if (WR && hit_mid) begin
            table_base_bits_23_16 <= WDATA[ucb_pkg::BYTE_MSB:0];
        end
    end

    // Base address bits 31:24
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            table_base_bits_31_24 <= ucb_pkg::RST_BASE_BYTE;
        end else if (WR && hit_high) begin
            table_base_bits_31_24 <= WDATA[ucb_pkg::BYTE_MSB:0];
        end
    end

    // Configuration controls; upper bits of the write word are dropped
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cfg <= ucb_pkg::RST_CFG;
        end else if (WR && hit_cfg) begin
            cfg.eye_pattern_test_enable <= WDATA[ucb_pkg::CFG_EYE_BIT];
            cfg.drive_enable_monitor    <= WDATA[ucb_pkg::CFG_OEMON_BIT];
            cfg.halt_in_idle            <= WDATA[ucb_pkg::CFG_HALT_BIT];
            cfg.auto_suspend_on_sleep   <= WDATA[ucb_pkg::CFG_ASUSP_BIT];
        end
    end

    // Read mux; unmapped addresses and idle cycles return zero
    always_comb begin
        next_rdata = ucb_pkg::ZERO_WORD;
        if (RD) begin
            case (1'b1)
                hit_low: begin
                    next_rdata[ucb_pkg::LOW_FIELD_MSB:ucb_pkg::LOW_FIELD_LSB] = table_base_bits_15_9;
                end
                hit_mid: begin
                    next_rdata[ucb_pkg::BYTE_MSB:0] = table_base_bits_23_16;
                end
                hit_high: begin
                    next_rdata[ucb_pkg::BYTE_MSB:0] = table_base_bits_31_24;
                end
                hit_cfg: begin
                    next_rdata[ucb_pkg::CFG_EYE_BIT]   = cfg.eye_pattern_test_enable;
                    next_rdata[ucb_pkg::CFG_OEMON_BIT] = cfg.drive_enable_monitor;
                    next_rdata[ucb_pkg::CFG_HALT_BIT]  = cfg.halt_in_idle;
                    next_rdata[ucb_pkg::CFG_ASUSP_BIT] = cfg.auto_suspend_on_sleep;
                end
                default: begin
                    next_rdata = ucb_pkg::ZERO_WORD;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            RDATA <= ucb_pkg::ZERO_WORD;
        end else begin
            RDATA <= next_rdata;
        end
    end

    // Assembled table base, low nine bits forced to zero
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            TABLE_BASE <= ucb_pkg::ZERO_WORD;
        end else begin
            TABLE_BASE <= {table_base_bits_31_24, table_base_bits_23_16,
                           table_base_bits_15_9, ucb_pkg::ZERO_ALIGN};
        end
    end

    // Power-state decisions
    assign next_halt    = SYSTEM_IDLE && cfg.halt_in_idle;
    assign next_suspend = (SYSTEM_SLEEP && cfg.auto_suspend_on_sleep) || MANUAL_SUSPEND;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            MODULE_HALTED <= 1'b0;
        end else begin
            MODULE_HALTED <= next_halt;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            MODULE_SUSPEND <= 1'b0;
            CLK48_STOP     <= 1'b0;
        end else begin
            MODULE_SUSPEND <= next_suspend;
            CLK48_STOP     <= next_suspend;
        end
    end

    // Eye-pattern test drives the lines whenever its control is set
    assign eye_run = cfg.eye_pattern_test_enable;

    ucb_eye_gen u_eye (
        .clk    (CLK),
        .rst    (SYS_RST),
        .enable (eye_run),
        .line   (eye_line)
    );

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            EYE_OE <= 1'b0;
            EYE_DP <= 1'b0;
            EYE_DM <= 1'b0;
        end else begin
            EYE_OE <= eye_run;
            EYE_DP <= eye_run && eye_line.dp;
            EYE_DM <= eye_run && eye_line.dm;
        end
    end

    // Drive-enable indication covers the transceiver and the eye test
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            OE_MONITOR <= 1'b0;
        end else begin
            OE_MONITOR <= cfg.drive_enable_monitor && (LINE_DRIVE || eye_run);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    default clocking ck @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    sequence s_write(logic [7:0] a);
        WR && (ADDR == a);
    endsequence

    sequence s_read_next(logic [7:0] a);
        ##1 (RD && (ADDR == a) && !WR);
    endsequence

    a_low_field_store: assert property (
        s_write(ucb_pkg::OFS_BASE_LOW) |=> table_base_bits_15_9 == $past(WDATA[7:1]))
        else $error("low base field not stored");

    a_mid_field_store: assert property (
        s_write(ucb_pkg::OFS_BASE_MID) |=> ##1 TABLE_BASE[23:16] == $past(WDATA[7:0], 2))
        else $error("mid base field not on table base");

    a_high_field_store: assert property (
        s_write(ucb_pkg::OFS_BASE_HIGH) |=> ##1 TABLE_BASE[31:24] == $past(WDATA[7:0], 2))
        else $error("high base field not on table base");

    a_base_aligned: assert property (
        TABLE_BASE[8:0] == ucb_pkg::ZERO_ALIGN && TABLE_BASE[15:9] == $past(table_base_bits_15_9))
        else $error("table base not aligned or stale");

    a_low_bit_zero: assert property (
        RD && hit_low |=> RDATA[0] == 1'b0)
        else $error("low page bit 0 reads one");

    a_upper_reads_zero: assert property (
        RD |=> RDATA[31:8] == ucb_pkg::ZERO_UPPER)
        else $error("upper bits read nonzero");

    a_eye_drive_on: assert property (
        WR && hit_cfg |=> ##1 EYE_OE == $past(WDATA[7], 2))
        else $error("eye test drive does not follow control");

    a_oe_monitor_gate: assert property (
        ##1 OE_MONITOR == ($past(cfg.drive_enable_monitor) && ($past(LINE_DRIVE) || $past(eye_run))))
        else $error("drive monitor wrong");

    a_idle_halt: assert property (
        SYSTEM_IDLE && cfg.halt_in_idle |=> MODULE_HALTED)
        else $error("module not halted in idle");

    a_idle_continue: assert property (
        !cfg.halt_in_idle |=> !MODULE_HALTED)
        else $error("module halted while continue selected");

    a_auto_suspend: assert property (
        SYSTEM_SLEEP && cfg.auto_suspend_on_sleep |=> MODULE_SUSPEND && CLK48_STOP)
        else $error("no auto suspend on sleep");

    a_manual_only: assert property (
        !cfg.auto_suspend_on_sleep && !MANUAL_SUSPEND |=> !MODULE_SUSPEND && !CLK48_STOP)
        else $error("suspend without manual control");

    a_reset_clear: assert property (disable iff (1'b0)
        SYS_RST |=> table_base_bits_15_9 == ucb_pkg::RST_BASE_LOW && cfg == ucb_pkg::RST_CFG
        && table_base_bits_23_16 == ucb_pkg::RST_BASE_BYTE && table_base_bits_31_24 == ucb_pkg::RST_BASE_BYTE)
        else $error("register not zero after reset");

    a_write_read_back: assert property (
        (s_write(ucb_pkg::OFS_BASE_MID) ##0 s_read_next(ucb_pkg::OFS_BASE_MID)) |=> RDATA[7:0] == $past(WDATA[7:0], 2))
        else $error("written value not read back next cycle");

endmodule

`default_nettype wire

// file: sim/ucb_cable_model.sv
/*
 Cable-side observer of the eye-pattern test: counts line changes and
 flags driven cycles where D+ and D- are not complementary.
 Assumes the lines are sampled on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ucb_cable_model (
    input  wire logic        clk,      // System clock
    input  wire logic        oe,       // Lines driven by the device
    input  wire logic        dp,       // D+
    input  wire logic        dm,       // D-
    output logic      [15:0] toggles,  // Line changes seen
    output logic      [7:0]  diff_bad  // Non-differential samples
);
    logic last_dp;

    initial begin
        toggles = 16'h0000;
        diff_bad = 8'h00;
        last_dp = 1'b0;
    end

    always @(posedge clk) begin
        if (oe && dp !== last_dp) begin
            toggles <= toggles + 16'h0001;
        end
        if (oe && dp === dm) begin
            diff_bad <= diff_bad + 8'h01;
        end
        last_dp <= dp;
    end
endmodule

`default_nettype wire

// file: sim/usb_descriptor_base_and_config_tb_top.sv
/*
 Bench for the table base and configuration slice: reference model in
 integer arrays, register tasks, power-state and eye-pattern checks.
 Assumes the design package and cable model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module usb_descriptor_base_and_config_tb_top;
    logic        CLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic [7:0]  ADDR = 8'h00;
    logic [31:0] WDATA = 32'h00000000;
    logic        WR = 1'b0;
    logic        RD = 1'b0;
    logic        sys_idle = 1'b0;
    logic        sys_sleep = 1'b0;
    logic        man_susp = 1'b0;
    logic        line_drv = 1'b0;
    logic [31:0] RDATA;
    logic [31:0] TABLE_BASE;
    logic        EYE_OE;
    logic        EYE_DP;
    logic        EYE_DM;
    logic        OE_MONITOR;
    logic        MODULE_HALTED;
    logic        MODULE_SUSPEND;
    logic        CLK48_STOP;
    logic [15:0] toggles;
    logic [15:0] t0;
    logic [7:0]  diff_bad;
    logic [7:0]  ofs [4] = '{ucb_pkg::OFS_BASE_LOW, ucb_pkg::OFS_BASE_MID,
                             ucb_pkg::OFS_BASE_HIGH, ucb_pkg::OFS_CONFIG};
    int          msk [4] = '{32'hFE, 32'hFF, 32'hFF, 32'hD1};
    int          mdl [4] = '{0, 0, 0, 0};
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          seed = 24;
    int          w;

    always #12.5 CLK = ~CLK;

    ucb_config ucb_config_inst (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .SYSTEM_IDLE(sys_idle), .SYSTEM_SLEEP(sys_sleep),
        .MANUAL_SUSPEND(man_susp), .LINE_DRIVE(line_drv), .TABLE_BASE(TABLE_BASE),
        .EYE_OE(EYE_OE), .EYE_DP(EYE_DP), .EYE_DM(EYE_DM), .OE_MONITOR(OE_MONITOR),
        .MODULE_HALTED(MODULE_HALTED), .MODULE_SUSPEND(MODULE_SUSPEND), .CLK48_STOP(CLK48_STOP));

    ucb_cable_model ucb_cable_model_inst (.clk(CLK), .oe(EYE_OE), .dp(EYE_DP), .dm(EYE_DM),
        .toggles(toggles), .diff_bad(diff_bad));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // Index 4 is an unmapped address
    task automatic wr(input int i, input logic [31:0] d);
        @(posedge CLK);
        ADDR <= (i < 4) ? ofs[i] : 8'h10;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        if (i < 4) mdl[i] = d & msk[i];
    endtask

    task automatic rd(input int i);
        @(posedge CLK);
        ADDR <= (i < 4) ? ofs[i] : 8'h10;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 chk("rdata", RDATA, (i < 4) ? mdl[i] : 0);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        repeat (16) @(posedge CLK);
        SYS_RST <= 1'b0;
        for (int i = 0; i < 5; i++) rd(i);
        $display("test reset values done");
        for (int k = 0; k < 12; k++) begin
            for (int i = 0; i < 5; i++) wr(i, $random(seed));
            for (int i = 0; i < 5; i++) rd(i);
            chk("table_base", TABLE_BASE, (mdl[2] << 24) | (mdl[1] << 16) | (mdl[0] << 8));
        end
        $display("test register access done");
        for (int k = 0; k < 24; k++) begin
            wr(3, $random(seed));
            @(posedge CLK);
            {sys_idle, sys_sleep, man_susp, line_drv} <= 4'($random(seed));
            repeat (2) @(posedge CLK);
            #1 chk("halted", MODULE_HALTED, sys_idle & mdl[3][4]);
            chk("suspend", MODULE_SUSPEND, (sys_sleep & mdl[3][0]) | man_susp);
            chk("clk48_stop", CLK48_STOP, (sys_sleep & mdl[3][0]) | man_susp);
            chk("oe_monitor", OE_MONITOR, mdl[3][6] & (line_drv | mdl[3][7]));
        end
        $display("test power states done");
        wr(3, 32'h80);
        for (w = 0; w < 10 && EYE_OE !== 1'b1; w++) @(posedge CLK);
        chk("eye_oe", EYE_OE, 1'b1);
        if (w == 10) tally_and_finish();
        t0 = toggles;
        repeat (30) @(posedge CLK);
        #1 chk("eye_toggles", (toggles - t0) >= 16'd8, 1'b1);
        chk("eye_diff", diff_bad, 8'h00);
        wr(3, 32'h00);
        repeat (3) @(posedge CLK);
        #1 chk("eye_off", {EYE_OE, EYE_DP, EYE_DM}, 3'b000);
        $display("test eye pattern done");
        @(posedge CLK);
        SYS_RST <= 1'b1;
        repeat (2) @(posedge CLK);
        SYS_RST <= 1'b0;
        mdl = '{0, 0, 0, 0};
        for (int i = 0; i < 4; i++) rd(i);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
